// file: verilog/mua_pkg.sv
// Constants and types for the single-operand ALU slice
// How it works
// - complement_in_place inverts the addressed byte, writes it back and updates zero.
// - complement_to_acc loads the inverted byte into the accumulator, memory untouched, zero updated.
// - bcd_adjust adds 6 to the low nibble when it is above 9 or aux carry is set.
// - bcd_adjust adds 6 to the high nibble when it is above 9 or carry is set.
// - bcd_adjust adds 00h, 06h, 60h or 66h to the accumulator and stores the sum in memory.
// - bcd_adjust writes the addressed memory byte and leaves the accumulator alone.
// - bcd_adjust changes only carry, which is set when the 60h correction is added or the sum overflows eight bits.
// - minus_one_in_place subtracts one from the byte, writes it back and updates zero.
// - minus_one_to_acc loads byte minus one into the accumulator, memory kept, zero updated.
// - plus_one_in_place adds one to the byte, writes it back and updates zero.
// - plus_one_to_acc loads byte plus one into the accumulator, memory kept, zero updated.
// - power_down stops execution and raises halt_o; ref_clk_i keeps running.
// - power_down keeps all memory and register contents.
// - power_down clears the watchdog count and its prescaler.
// - power_down sets power_down_flag.
// - power_down clears watchdog_timeout_flag unless wdt_timeout_i is also high, and changes no other flag apart from power_down_flag and the halt flag.
package mua_pkg;

  localparam int unsigned AVS_AW       = 5;
  localparam logic [4:0]  OFF_CMD      = 5'h00;
  localparam logic [4:0]  OFF_ACC      = 5'h04;
  localparam logic [4:0]  OFF_STAT     = 5'h08;
  localparam logic [4:0]  OFF_MADDR    = 5'h0C;
  localparam logic [4:0]  OFF_MDATA    = 5'h10;

  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_OP_W     = 3;
  localparam int unsigned CMD_ADDR_LSB = 8;

  localparam int unsigned STAT_Z       = 0;
  localparam int unsigned STAT_C       = 1;
  localparam int unsigned STAT_AC      = 2;
  localparam int unsigned STAT_PWRDN   = 3;
  localparam int unsigned STAT_TO      = 4;
  localparam int unsigned STAT_HALT    = 5;
  localparam int unsigned STAT_BUSY    = 6;

  localparam logic [7:0]  RST_ACC      = 8'h00;
  localparam logic [7:0]  RST_ADDR     = 8'h00;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
  localparam logic        RST_FLAG     = 1'b0;

  localparam logic [3:0]  BCD_LIMIT    = 4'h9;
  localparam logic [7:0]  ADJ_NONE     = 8'h00;
  localparam logic [7:0]  ADJ_LO       = 8'h06;
  localparam logic [7:0]  ADJ_HI       = 8'h60;
  localparam logic [7:0]  ADJ_BOTH     = 8'h66;
  localparam logic [7:0]  ONE          = 8'h01;

  localparam logic [1:0]  RD_LAT       = 2'h2;

  typedef enum logic [2:0] {
    complement_in_place,
    complement_to_acc,
    bcd_adjust,
    minus_one_in_place,
    minus_one_to_acc,
    plus_one_in_place,
    plus_one_to_acc,
    power_down
  } mua_op_t;

endpackage : mua_pkg

// file: verilog/mua_exec_if.sv
// Operand and result bundle between core control and the ALU
`timescale 1ns/1ps
interface mua_exec_if;
  import mua_pkg::*;
  mua_op_t    op;
  logic [7:0] acc;
  logic [7:0] operand;
  logic       c_in;
  logic       ac_in;
  logic [7:0] result;
  logic       wr_mem;
  logic       wr_acc;
  logic       z_upd;
  logic       z_out;
  logic       c_upd;
  logic       c_out;

  modport alu (input op, acc, operand, c_in, ac_in,
               output result, wr_mem, wr_acc, z_upd, z_out, c_upd, c_out);
  modport core (output op, acc, operand, c_in, ac_in,
                input result, wr_mem, wr_acc, z_upd, z_out, c_upd, c_out);
endinterface : mua_exec_if

// file: verilog/mua_dmem.sv
// Byte-wide data memory with registered read port
`timescale 1ns/1ps
module mua_dmem #(
  parameter int unsigned AW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem_q [2**AW];

  // No reset or clear path, contents survive power-down
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule : mua_dmem

// file: verilog/mua_exec.sv
// Single-operand arithmetic and flag logic
`timescale 1ns/1ps
module mua_exec (
  mua_exec_if.alu ex
);
  import mua_pkg::*;

  logic       lo_adj;
  logic       hi_adj;
  logic [7:0] adj;
  logic [8:0] bcd_sum;
  logic [7:0] res;

  always_comb begin
    lo_adj  = (ex.acc[3:0] > BCD_LIMIT) || ex.ac_in;
    hi_adj  = (ex.acc[7:4] > BCD_LIMIT) || ex.c_in;
    case ({hi_adj, lo_adj})
      2'b00:   adj = ADJ_NONE;
      2'b01:   adj = ADJ_LO;
      2'b10:   adj = ADJ_HI;
      default: adj = ADJ_BOTH;
    endcase
    bcd_sum   = {1'b0, ex.acc} + {1'b0, adj};
    res       = ex.operand;
    ex.wr_mem = 1'b0;
    ex.wr_acc = 1'b0;
    ex.z_upd  = 1'b1;
    ex.c_upd  = 1'b0;
    ex.c_out  = ex.c_in;
    // Eight-bit sums wrap
    case (ex.op)
      complement_in_place: begin
        res       = ~ex.operand;
        ex.wr_mem = 1'b1;
      end
      complement_to_acc: begin
        res       = ~ex.operand;
        ex.wr_acc = 1'b1;
      end
      bcd_adjust: begin
        res       = bcd_sum[7:0];
        ex.wr_mem = 1'b1;
        ex.z_upd  = 1'b0;
        ex.c_upd  = 1'b1;
        ex.c_out  = hi_adj | bcd_sum[8];
      end
      minus_one_in_place: begin
        res       = ex.operand - ONE;
        ex.wr_mem = 1'b1;
      end
      minus_one_to_acc: begin
        res       = ex.operand - ONE;
        ex.wr_acc = 1'b1;
      end
      plus_one_in_place: begin
        res       = ex.operand + ONE;
        ex.wr_mem = 1'b1;
      end
      plus_one_to_acc: begin
        res       = ex.operand + ONE;
        ex.wr_acc = 1'b1;
      end
      default: begin
        ex.z_upd  = 1'b0;
      end
    endcase
    ex.result = res;
    ex.z_out  = (res == ADJ_NONE);
  end
endmodule : mua_exec

// file: verilog/mua_alu_top.sv
// Top of the single-operand ALU slice with Avalon-MM register port
`timescale 1ns/1ps
module mua_alu_top #(
  parameter int unsigned MEM_AW = 8
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [mua_pkg::AVS_AW-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire logic                       wdt_timeout_i,
  input  wire logic                       wake_i,
  output logic                            halt_o,
  output logic                            wdt_clr_o
);
  import mua_pkg::*;

  typedef enum {ST_IDLE, ST_FETCH, ST_EXEC} mua_state_t;

  mua_state_t  state_q;
  mua_state_t  state_d;
  mua_op_t     op_q;
  mua_op_t     op_d;
  mua_op_t     cmd_op;
  logic [7:0]  addr_q;
  logic [7:0]  addr_d;
  logic [7:0]  maddr_q;
  logic [7:0]  maddr_d;
  logic [7:0]  acc_q;
  logic [7:0]  acc_d;
  logic        z_q;
  logic        z_d;
  logic        c_q;
  logic        c_d;
  logic        ac_q;
  logic        ac_d;
  logic        power_down_flag_q;
  logic        power_down_flag_d;
  logic        to_q;
  logic        to_d;
  logic        halted_q;
  logic        halted_d;
  logic        wdt_clr_q;
  logic        wdt_clr_d;
  logic [1:0]  rd_cnt_q;
  logic [1:0]  rd_cnt_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wake_s1_q;
  logic        wake_s2_q;
  logic        wake_s3_q;
  logic        wake_rise;
  logic        busy;
  logic        wr_ok;
  logic        launch;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_addr;
  logic [7:0]  mem_rdata;
  logic [31:0] reg_word;

  mua_exec_if ex_if ();

  assign ex_if.op      = op_q;
  assign ex_if.acc     = acc_q;
  assign ex_if.operand = mem_rdata;
  assign ex_if.c_in    = c_q;
  assign ex_if.ac_in   = ac_q;

  mua_exec u_exec (
    .ex (ex_if.alu)
  );

  mua_dmem #(
    .AW (MEM_AW)
  ) u_dmem (
    .clk_i   (ref_clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr[MEM_AW-1:0]),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // Wake pin synchroniser and edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wake_s1_q <= RST_FLAG;
      wake_s2_q <= RST_FLAG;
      wake_s3_q <= RST_FLAG;
    end else begin
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  assign wake_rise = wake_s2_q & ~wake_s3_q;

  // Bus handshake
  assign busy   = (state_q != ST_IDLE);
  assign wr_ok  = avs_write_i & ~busy;
  assign cmd_op = mua_op_t'(avs_writedata_i[CMD_OP_LSB +: CMD_OP_W]);
  assign launch = wr_ok & (avs_address_i == OFF_CMD) & avs_byteenable_i[0] & ~halted_q;

  assign avs_waitrequest_o = (avs_write_i & busy) |
                             (avs_read_i & (busy | (rd_cnt_q != RD_LAT)));
  assign avs_readdata_o    = rdata_q;
  assign halt_o            = halted_q;
  assign wdt_clr_o         = wdt_clr_q;

  // Register read mux
  always_comb begin
    reg_word = RST_RDATA;
    case (avs_address_i)
      OFF_CMD: begin
        reg_word[CMD_OP_LSB +: CMD_OP_W] = op_q;
        reg_word[CMD_ADDR_LSB +: 8]      = addr_q;
      end
      OFF_ACC:   reg_word[7:0] = acc_q;
      OFF_STAT: begin
        reg_word[STAT_Z]    = z_q;
        reg_word[STAT_C]    = c_q;
        reg_word[STAT_AC]   = ac_q;
        reg_word[STAT_PWRDN] = power_down_flag_q;
        reg_word[STAT_TO]   = to_q;
        reg_word[STAT_HALT] = halted_q;
        reg_word[STAT_BUSY] = busy;
      end
      OFF_MADDR: reg_word[7:0] = maddr_q;
      OFF_MDATA: reg_word[7:0] = mem_rdata;
      default:   reg_word = RST_RDATA;
    endcase
  end

  // Next state of engine, flags and bus registers
  always_comb begin
    state_d   = state_q;
    op_d      = op_q;
    addr_d    = addr_q;
    maddr_d   = maddr_q;
    acc_d     = acc_q;
    z_d       = z_q;
    c_d       = c_q;
    ac_d      = ac_q;
    power_down_flag_d = power_down_flag_q;
    to_d      = to_q;
    halted_d  = halted_q;
    wdt_clr_d = 1'b0;
    rd_cnt_d  = rd_cnt_q;
    rdata_d   = rdata_q;
    mem_we    = 1'b0;
    mem_wdata = ex_if.result;
    mem_addr  = busy ? addr_q : maddr_q;
    case (state_q)
      ST_IDLE: begin
        if (launch) begin
          op_d = cmd_op;
          if (avs_byteenable_i[1]) begin
            addr_d = avs_writedata_i[CMD_ADDR_LSB +: 8];
          end
          if (cmd_op == power_down) begin
            halted_d  = 1'b1;
            wdt_clr_d = 1'b1;
            power_down_flag_d = 1'b1;
            to_d      = 1'b0;
          end else begin
            state_d = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        mem_we = ex_if.wr_mem;
        if (ex_if.wr_acc) begin
          acc_d = ex_if.result;
        end
        if (ex_if.z_upd) begin
          z_d = ex_if.z_out;
        end
        if (ex_if.c_upd) begin
          c_d = ex_if.c_out;
        end
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (wr_ok && avs_byteenable_i[0]) begin
      case (avs_address_i)
        OFF_ACC:   acc_d   = avs_writedata_i[7:0];
        OFF_MADDR: maddr_d = avs_writedata_i[7:0];
        OFF_MDATA: begin
          mem_we    = 1'b1;
          mem_wdata = avs_writedata_i[7:0];
        end
        OFF_STAT: begin
          z_d   = avs_writedata_i[STAT_Z];
          c_d   = avs_writedata_i[STAT_C];
          ac_d  = avs_writedata_i[STAT_AC];
          power_down_flag_d = avs_writedata_i[STAT_PWRDN];
          to_d  = avs_writedata_i[STAT_TO];
        end
        default: begin
        end
      endcase
    end
    if (avs_read_i && !busy) begin
      if (rd_cnt_q == RD_LAT) begin
        rd_cnt_d = 2'h0;
      end else begin
        rd_cnt_d = rd_cnt_q + 2'h1;
      end
      if (rd_cnt_q == 2'h1) begin
        rdata_d = reg_word;
      end
    end
    if (wdt_timeout_i) begin
      to_d = 1'b1;
    end
    if (halted_q && wake_rise) begin
      halted_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_IDLE;
      op_q      <= complement_in_place;
      addr_q    <= RST_ADDR;
      maddr_q   <= RST_ADDR;
      acc_q     <= RST_ACC;
      z_q       <= RST_FLAG;
      c_q       <= RST_FLAG;
      ac_q      <= RST_FLAG;
      power_down_flag_q <= RST_FLAG;
      to_q      <= RST_FLAG;
      halted_q  <= RST_FLAG;
      wdt_clr_q <= RST_FLAG;
      rd_cnt_q  <= 2'h0;
      rdata_q   <= RST_RDATA;
    end else begin
      state_q   <= state_d;
      op_q      <= op_d;
      addr_q    <= addr_d;
      maddr_q   <= maddr_d;
      acc_q     <= acc_d;
      z_q       <= z_d;
      c_q       <= c_d;
      ac_q      <= ac_d;
      power_down_flag_q <= power_down_flag_d;
      to_q      <= to_d;
      halted_q  <= halted_d;
      wdt_clr_q <= wdt_clr_d;
      rd_cnt_q  <= rd_cnt_d;
      rdata_q   <= rdata_d;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic ex_now;
  logic halt_go;
  logic bcd_lo;
  logic bcd_hi;
  assign ex_now  = (state_q == ST_EXEC);
  assign halt_go = launch && (cmd_op == power_down);
  assign bcd_lo  = (acc_q[3:0] > BCD_LIMIT) || ac_q;
  assign bcd_hi  = (acc_q[7:4] > BCD_LIMIT) || c_q;

  a_compl_write_back: assert property (
    ex_now && op_q == complement_in_place |-> mem_we && mem_wdata == ~mem_rdata
      ##1 z_q == ($past(mem_rdata) == 8'hFF))
    else $error("complement in place wrong");

  a_compl_acc_load: assert property (
    ex_now && op_q == complement_to_acc |-> !mem_we ##1 acc_q == ~$past(mem_rdata)
      && z_q == ($past(mem_rdata) == 8'hFF))
    else $error("complement to acc wrong");

  a_bcd_low_nib: assert property (
    ex_now && op_q == bcd_adjust |->
      mem_wdata[3:0] == (bcd_lo ? acc_q[3:0] + 4'h6 : acc_q[3:0]))
    else $error("bcd low nibble wrong");

  a_bcd_sum_val: assert property (
    ex_now && op_q == bcd_adjust |->
      mem_wdata == acc_q + (bcd_lo ? ADJ_LO : ADJ_NONE) + (bcd_hi ? ADJ_HI : ADJ_NONE))
    else $error("bcd sum wrong");

  a_bcd_to_mem: assert property (
    ex_now && op_q == bcd_adjust |-> mem_we ##1 $stable(acc_q) && $stable(z_q))
    else $error("bcd adjust target wrong");

  a_bcd_carry_set: assert property (
    ex_now && op_q == bcd_adjust && bcd_hi |=> c_q)
    else $error("bcd carry not set");

  a_minus_in_place: assert property (
    ex_now && op_q == minus_one_in_place |-> mem_we && mem_wdata == mem_rdata - ONE)
    else $error("decrement in place wrong");

  a_minus_acc_zero: assert property (
    ex_now && op_q == minus_one_to_acc |-> !mem_we
      ##1 acc_q == $past(mem_rdata) - ONE && z_q == (acc_q == 8'h00))
    else $error("decrement to acc wrong");

  a_inc_wrap: assert property (
    ex_now && op_q == plus_one_in_place && mem_rdata == 8'hFF |->
      mem_we && mem_wdata == 8'h00 ##1 z_q)
    else $error("increment wrap wrong");

  a_plus_acc_load: assert property (
    ex_now && op_q == plus_one_to_acc |-> !mem_we ##1 acc_q == $past(mem_rdata) + ONE)
    else $error("increment to acc wrong");

  a_halt_flags: assert property (
    halt_go && !wdt_timeout_i |=> power_down_flag_q && !to_q && wdt_clr_o && $stable(z_q)
      && $stable(c_q) ##1 !wdt_clr_o)
    else $error("power down flags wrong");

  a_halt_stops: assert property (
    halt_go |=> halted_q && halt_o && state_q == ST_IDLE && $stable(acc_q))
    else $error("power down did not stop");

  c_bcd_both: cover property (ex_now && op_q == bcd_adjust && bcd_lo && bcd_hi);
  c_inc_wrap: cover property (ex_now && op_q == plus_one_in_place && mem_rdata == 8'hFF);
  c_halt_wake: cover property (halt_go ##[1:20] !halted_q);
endmodule : mua_alu_top

// file: verification/tb_top.sv
// Self-checking bench for the single-operand ALU slice
`timescale 1ns/1ps
module tb_top;
  import mua_pkg::*;

  logic                ref_clk_i        = 1'b0;
  logic                rst_n_i          = 1'b0;
  logic [AVS_AW-1:0]   avs_address_i    = 5'h00;
  logic                avs_read_i       = 1'b0;
  logic                avs_write_i      = 1'b0;
  logic [31:0]         avs_writedata_i  = 32'h0000_0000;
  logic [3:0]          avs_byteenable_i = 4'hF;
  logic [31:0]         avs_readdata_o;
  logic                avs_waitrequest_o;
  logic                wdt_timeout_i    = 1'b0;
  logic                wake_i           = 1'b0;
  logic                halt_o;
  logic                wdt_clr_o;
  int                  errors           = 0;
  int                  num_checks       = 0;
  logic [7:0]          res;
  logic [7:0]          v;
  logic [8:0]          sum;
  logic                lo;
  logic                hi;
  mua_op_t             ops [6] = '{complement_in_place, complement_to_acc, minus_one_in_place,
                                   minus_one_to_acc, plus_one_in_place, plus_one_to_acc};
  logic [7:0]          vals [4] = '{8'h00, 8'h01, 8'hFF, 8'h5A};
  logic [9:0]          bcd [7] = '{{8'h45, 2'b00}, {8'h4B, 2'b00}, {8'hA3, 2'b00}, {8'h22, 2'b01},
                                   {8'h22, 2'b10}, {8'hCC, 2'b00}, {8'h99, 2'b11}};

  always #2 ref_clk_i = ~ref_clk_i;

  mua_alu_top #(.MEM_AW(8)) mua_alu_top_i (
    .ref_clk_i         (ref_clk_i),
    .rst_n_i           (rst_n_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .wdt_timeout_i     (wdt_timeout_i),
    .wake_i            (wake_i),
    .halt_o            (halt_o),
    .wdt_clr_o         (wdt_clr_o)
  );

  task automatic conclude();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (avs_waitrequest_o !== 1'b0) begin
      errors++;
      conclude();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rd_chk

  task automatic run(input mua_op_t op, input logic [7:0] a);
    logic [31:0] d;
    d       = 32'h0000_0000;
    d[2:0]  = op;
    d[15:8] = a;
    wr(OFF_CMD, d);
  endtask : run

  task automatic set_mem(input logic [7:0] a, input logic [7:0] d);
    wr(OFF_MADDR, {24'h00_0000, a});
    wr(OFF_MDATA, {24'h00_0000, d});
  endtask : set_mem

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Reset state and unmapped space
    rd_chk(OFF_ACC, 32'h0000_0000);
    rd_chk(OFF_STAT, 32'h0000_0000);
    rd_chk(OFF_CMD, 32'h0000_0000);
    wr(5'h14, 32'h0000_00AA);
    rd_chk(5'h14, 32'h0000_0000);
    check({31'h0000_0000, halt_o}, 32'h0000_0000);
    // Write without lane 0 is dropped
    avs_byteenable_i <= 4'hE;
    wr(OFF_ACC, 32'h0000_0055);
    avs_byteenable_i <= 4'hF;
    rd_chk(OFF_ACC, 32'h0000_0000);
    // Single-operand ops over boundary values
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        v = vals[j];
        case (ops[i])
          complement_in_place, complement_to_acc: res = ~v;
          minus_one_in_place, minus_one_to_acc:   res = v - 8'h01;
          default:                                res = v + 8'h01;
        endcase
        set_mem(8'h20 + 8'(i), v);
        set_mem(8'h21 + 8'(i), 8'hC3);
        wr(OFF_ACC, 32'h0000_003C);
        wr(OFF_STAT, 32'h0000_0006);
        run(ops[i], 8'h20 + 8'(i));
        wr(OFF_MADDR, {24'h00_0000, 8'h20 + 8'(i)});
        if (ops[i] inside {complement_to_acc, minus_one_to_acc, plus_one_to_acc}) begin
          rd_chk(OFF_ACC, {24'h00_0000, res});
          rd_chk(OFF_MDATA, {24'h00_0000, v});
        end else begin
          rd_chk(OFF_MDATA, {24'h00_0000, res});
          rd_chk(OFF_ACC, 32'h0000_003C);
        end
        rd_chk(OFF_STAT, {31'h0000_0003, res == 8'h00});
        wr(OFF_MADDR, {24'h00_0000, 8'h21 + 8'(i)});
        rd_chk(OFF_MDATA, 32'h0000_00C3);
      end
    end
    // Decimal adjust across all four corrections
    for (int k = 0; k < 7; k++) begin
      v   = bcd[k][9:2];
      lo  = (v[3:0] > 4'h9) || bcd[k][0];
      hi  = (v[7:4] > 4'h9) || bcd[k][1];
      sum = {1'b0, v} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
      set_mem(8'h40, 8'h77);
      wr(OFF_ACC, {24'h00_0000, v});
      wr(OFF_STAT, {27'h000_0000, 1'b0, 1'b0, bcd[k][0], bcd[k][1], 1'b1});
      run(bcd_adjust, 8'h40);
      rd_chk(OFF_MDATA, {24'h00_0000, sum[7:0]});
      rd_chk(OFF_ACC, {24'h00_0000, v});
      rd_chk(OFF_STAT, {29'h0000_0000, bcd[k][0], bcd[k][1] | hi | sum[8], 1'b1});
    end
    // Power-down entry, refused command while halted, wake
    set_mem(8'h50, 8'hA5);
    wr(OFF_ACC, 32'h0000_005E);
    wr(OFF_STAT, 32'h0000_0013);
    run(power_down, 8'h50);
    @(negedge ref_clk_i);
    check({30'h0000_0000, halt_o, wdt_clr_o}, 32'h0000_0003);
    @(negedge ref_clk_i);
    check({31'h0000_0000, wdt_clr_o}, 32'h0000_0000);
    rd_chk(OFF_STAT, 32'h0000_002B);
    run(plus_one_in_place, 8'h50);
    rd_chk(OFF_MDATA, 32'h0000_00A5);
    rd_chk(OFF_ACC, 32'h0000_005E);
    rd_chk(OFF_MADDR, 32'h0000_0050);
    @(posedge ref_clk_i);
    wake_i <= 1'b1;
    for (int n = 0; n < 20 && halt_o !== 1'b0; n++) begin
      @(negedge ref_clk_i);
    end
    check({31'h0000_0000, halt_o}, 32'h0000_0000);
    @(posedge ref_clk_i);
    wake_i <= 1'b0;
    // Watchdog time-out pulse sets its flag
    wr(OFF_STAT, 32'h0000_0000);
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'b0;
    rd_chk(OFF_STAT, 32'h0000_0010);
    run(plus_one_in_place, 8'h50);
    rd_chk(OFF_MDATA, 32'h0000_00A6);
    rd_chk(OFF_STAT, 32'h0000_0010);
    // Command without lane 1 keeps the old address
    avs_byteenable_i <= 4'h1;
    run(plus_one_in_place, 8'h99);
    avs_byteenable_i <= 4'hF;
    rd_chk(OFF_CMD, 32'h0000_5005);
    rd_chk(OFF_MDATA, 32'h0000_00A7);
    conclude();
  end
endmodule : tb_top
